// [rsa_pkg.sv]
/*
 * Constants for the rail strobe slot assignment block: register
 * subaddresses, field positions, reset values and sequencer timing.
 * Assumes a 20 MHz core clock.
 */
package rsa_pkg;

   // ==========================================================
   // Register subaddresses
   localparam logic [7:0] ADDR_GAP_LO    = 8'h20;
   localparam logic [7:0] ADDR_GAP_HI    = 8'h21;
   localparam logic [7:0] ADDR_SLOT_A    = 8'h23;
   localparam logic [7:0] ADDR_SLOT_B    = 8'h24;

   // ==========================================================
   // Reset values and masks
   localparam logic [7:0] RST_GAP_LO     = 8'h00;
   localparam logic [7:0] RST_GAP_HI     = 8'h00;
   localparam logic [7:0] RST_SLOT_A     = 8'h75;
   localparam logic [7:0] RST_SLOT_B     = 8'h12;
   localparam logic [7:0] MASK_GAP_HI    = 8'h81;
   localparam logic [7:0] MASK_SLOT_B    = 8'h33;

   // ==========================================================
   // Field positions
   localparam int CONV4_SLOT_LSB         = 4;
   localparam int CONV3_SLOT_LSB         = 0;
   localparam int DOWN_FCTR_BIT          = 7;
   localparam int GAP9_BIT               = 0;

   // ==========================================================
   // Slot code map and strobe range
   localparam logic [3:0] SLOT_FIRST     = 4'h3;
   localparam logic [3:0] SLOT_LAST      = 4'hA;
   localparam logic [3:0] STROBE_FIRST   = 4'h1;
   localparam logic [3:0] STROBE_LAST    = 4'hA;
   localparam logic [3:0] GAP_COUNT      = 4'h9;

   // ==========================================================
   // Timing
   localparam int CLK_KHZ                = 20000;
   localparam int GAP_SHORT_US           = 2000;
   localparam int GAP_LONG_US            = 5000;
   localparam int GAP_SHORT_CYC          = GAP_SHORT_US * CLK_KHZ / 1000;
   localparam int GAP_LONG_CYC           = GAP_LONG_US * CLK_KHZ / 1000;
   localparam logic [23:0] DOWN_FACTOR   = 24'h00000A;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_UP   = 3'b010,
      SEQ_DOWN = 3'b100
   } rsa_state_t;

endpackage : rsa_pkg

// [rsa_rail_slot.sv]
/*
 * One rail's slot decoder: turns the rail on or off at its strobe.
 * Assumes strobe pulses and number come from the sequencer on the
 * same clock.
 */
`timescale 1ns/1ps
module rsa_rail_slot
   import rsa_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   // Slot and sequencer
   input  wire logic [3:0] slot_in,
   input  wire logic       strobe_in,
   input  wire logic [3:0] strobe_num_in,
   input  wire logic       going_up_in,
   // Direct enable
   input  wire logic       direct_en_in,
   // Rail enable
   output logic            rail_en_out
);

   logic seq_on_q;
   logic seq_on_d;
   logic rail_en_d;
   wire  in_seq = (slot_in >= SLOT_FIRST) && (slot_in <= SLOT_LAST);
   wire  hit    = in_seq && strobe_in && (strobe_num_in == slot_in);

   // Excluded rail drops any sequencer state it held
   assign seq_on_d  = !in_seq ? 1'b0 : (hit ? going_up_in : seq_on_q);
   // Excluded rail follows only its direct enable
   assign rail_en_d = in_seq ? (seq_on_d | direct_en_in)
                             : direct_en_in;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         seq_on_q    <= 1'b0;
         rail_en_out <= 1'b0;
      end else if (ce_in) begin
         seq_on_q    <= seq_on_d;
         rail_en_out <= rail_en_d;
      end
   end

endmodule : rsa_rail_slot

// [rsa_seq_core.sv]
/*
 * Strobe sequencer with gap delays and slot registers for the third
 * and the buck-boost converter rails.
 * Assumes the password unlock level, the start requests and the
 * direct enables come from device logic on the same clock.
 */
`timescale 1ns/1ps
// Contract
// - A slot code 3h..Ah enables the rail at the strobe of that number.
// - Codes 0h..2h and Bh..Fh leave the rail outside strobe control.
// - The buck-boost rail slot is bits 7:4 of slot register A, reset 7h.
// - The third rail slot is bits 3:0 of slot register A, reset 5h.
// - Slot register B sits at 0x24, resets to 0x12, writes need unlock.
// - Slot register A sits at 0x23, resets to 0x75, writes need unlock.
// - Each strobe gap waits 2 ms or 5 ms as its own gap bit selects, ten times as long going down when the down factor bit is set.
module rsa_seq_core
   import rsa_pkg::*;
#(
   parameter int unsigned GAP_SHORT = GAP_SHORT_CYC,
   parameter int unsigned GAP_LONG  = GAP_LONG_CYC
)(
   // Clock, reset, enable
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RESET_IN,
   input  wire logic       CLK_EN_IN,
   // Register access
   input  wire logic [7:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       REG_WR_IN,
   input  wire logic       REG_UNLOCK_IN,
   output logic      [7:0] REG_RDATA_OUT,
   // Sequencer control
   input  wire logic       SEQ_UP_IN,
   input  wire logic       SEQ_DOWN_IN,
   output logic            SEQ_BUSY_OUT,
   output logic            STROBE_OUT,
   output logic      [3:0] STROBE_NUM_OUT,
   // Rails: bit 0 third rail, bit 1 buck-boost rail
   input  wire logic [1:0] RAIL_DIRECT_EN_IN,
   output logic      [1:0] RAIL_EN_OUT
);

   // ==========================================================
   // Registers
   logic [7:0]  gap_lo_q;
   logic [7:0]  gap_hi_q;
   logic [7:0]  rail_slot_cfg_a_q;
   logic [7:0]  rail_slot_cfg_b_q;
   logic [7:0]  rdata_d;

   wire wr_ok   = CLK_EN_IN && REG_WR_IN && REG_UNLOCK_IN;
   wire wr_lo   = wr_ok && (REG_ADDR_IN == ADDR_GAP_LO);
   wire wr_hi   = wr_ok && (REG_ADDR_IN == ADDR_GAP_HI);
   wire wr_a    = wr_ok && (REG_ADDR_IN == ADDR_SLOT_A);
   wire wr_b    = wr_ok && (REG_ADDR_IN == ADDR_SLOT_B);

   always_comb begin
      unique case (REG_ADDR_IN)
         ADDR_GAP_LO: rdata_d = gap_lo_q;
         ADDR_GAP_HI: rdata_d = gap_hi_q;
         ADDR_SLOT_A: rdata_d = rail_slot_cfg_a_q;
         ADDR_SLOT_B: rdata_d = rail_slot_cfg_b_q;
         default:     rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         gap_lo_q          <= RST_GAP_LO;
         gap_hi_q          <= RST_GAP_HI;
         rail_slot_cfg_a_q <= RST_SLOT_A;
         rail_slot_cfg_b_q <= RST_SLOT_B;
         REG_RDATA_OUT     <= 8'h00;
      end else if (CLK_EN_IN) begin
         if (wr_lo) gap_lo_q <= REG_WDATA_IN;
         if (wr_hi) gap_hi_q <= REG_WDATA_IN & MASK_GAP_HI;
         if (wr_a) rail_slot_cfg_a_q <= REG_WDATA_IN;
         if (wr_b) rail_slot_cfg_b_q <= REG_WDATA_IN & MASK_SLOT_B;
         REG_RDATA_OUT <= rdata_d;
      end
   end

   // ==========================================================
   // Strobe sequencer
   rsa_state_t  state_q;
   rsa_state_t  state_d;
   logic [3:0]  num_q;
   logic [23:0] cnt_q;

   wire [8:0] gap_bits = {gap_hi_q[GAP9_BIT], gap_lo_q};
   wire       idle     = (state_q == SEQ_IDLE);
   wire       go_up    = idle ? SEQ_UP_IN : (state_q == SEQ_UP);
   wire       start    = idle && (SEQ_UP_IN || SEQ_DOWN_IN);
   wire       step     = !idle && (cnt_q == 24'h000000);
   wire       issue    = start || step;
   wire [3:0] num_n    = start ? (go_up ? STROBE_FIRST : STROBE_LAST)
                       : (go_up ? num_q + 4'h1 : num_q - 4'h1);
   wire       last_n   = go_up ? (num_n == STROBE_LAST)
                               : (num_n == STROBE_FIRST);
   // Gap that follows the strobe being issued
   wire [3:0] gap_idx  = go_up ? num_n - 4'h1 : num_n - 4'h2;
   wire       gap_long = (gap_idx < GAP_COUNT) && gap_bits[gap_idx];
   wire [23:0] base    = gap_long ? GAP_LONG[23:0] : GAP_SHORT[23:0];
   wire [23:0] prod    = 24'(base * DOWN_FACTOR);
   wire [23:0] gap_cyc = (!go_up && gap_hi_q[DOWN_FCTR_BIT]) ? prod : base;

   always_comb begin
      state_d = state_q;
      if (issue) begin
         if (last_n) state_d = SEQ_IDLE;
         else if (go_up) state_d = SEQ_UP;
         else state_d = SEQ_DOWN;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         state_q    <= SEQ_IDLE;
         num_q      <= 4'h0;
         cnt_q      <= 24'h000000;
         STROBE_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         state_q    <= state_d;
         STROBE_OUT <= issue;
         if (issue) begin
            num_q <= num_n;
            cnt_q <= gap_cyc - 24'h000001;
         end else if (!idle) begin
            cnt_q <= cnt_q - 24'h000001;
         end
      end
   end

   assign STROBE_NUM_OUT = num_q;
   assign SEQ_BUSY_OUT   = !idle;

   // Direction of the strobe on the output
   logic dir_up_q;
   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) dir_up_q <= 1'b1;
      else if (CLK_EN_IN && issue) dir_up_q <= go_up;
   end

   // ==========================================================
   // Rail decoders
   wire [7:0] slots = rail_slot_cfg_a_q;

   for (genvar i = 0; i < 2; i++) begin : g_rail
      rsa_rail_slot u_rail (
         .clk_in        (CORE_CLK_IN),
         .rst_in        (RESET_IN),
         .ce_in         (CLK_EN_IN),
         .slot_in       (slots[4*i +: 4]),
         .strobe_in     (STROBE_OUT),
         .strobe_num_in (num_q),
         .going_up_in   (dir_up_q),
         .direct_en_in  (RAIL_DIRECT_EN_IN[i]),
         .rail_en_out   (RAIL_EN_OUT[i])
      );
   end

endmodule : rsa_seq_core

// [rsa_seq_core_props.sv]
/* Port assertions for the slot sequencer.
   Assumes binding onto rsa_seq_core. */
`timescale 1ns/1ps
module rsa_seq_core_props
   import rsa_pkg::*;
(
   // Clock and control
   input wire logic       CORE_CLK_IN,
   input wire logic       RESET_IN,
   input wire logic       CLK_EN_IN,
   // Registers
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic       REG_WR_IN,
   input wire logic       REG_UNLOCK_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   // Sequencer and rails
   input wire logic       SEQ_UP_IN,
   input wire logic       SEQ_DOWN_IN,
   input wire logic       SEQ_BUSY_OUT,
   input wire logic       STROBE_OUT,
   input wire logic [3:0] STROBE_NUM_OUT,
   input wire logic [1:0] RAIL_DIRECT_EN_IN,
   input wire logic [1:0] RAIL_EN_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RESET_IN || !CLK_EN_IN);
   // ==========
   // Checks
   a_up_start: assert property (!SEQ_BUSY_OUT && SEQ_UP_IN |=> STROBE_OUT
      && STROBE_NUM_OUT == 4'h1 && SEQ_BUSY_OUT) else $error("bad up start");
   a_down_start: assert property (!SEQ_BUSY_OUT && !SEQ_UP_IN && SEQ_DOWN_IN
      |=> STROBE_OUT && STROBE_NUM_OUT == 4'hA) else $error("bad down start");
   a_strobe_pulse: assert property (STROBE_OUT && SEQ_BUSY_OUT
      |=> !STROBE_OUT) else $error("strobe too long");
   a_unmapped_read: assert property (REG_ADDR_IN > 8'h24 ||
      REG_ADDR_IN < 8'h20 || REG_ADDR_IN == 8'h22
      |=> REG_RDATA_OUT == 8'h00) else $error("unmapped data");
   a_slot_b_bits: assert property (REG_ADDR_IN == 8'h24
      |=> (REG_RDATA_OUT & 8'hCC) == 8'h00) else $error("reserved bits set");
   a_write_read: assert property (REG_WR_IN && REG_UNLOCK_IN &&
      REG_ADDR_IN == 8'h23 ##1 REG_ADDR_IN == 8'h23
      |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2)) else $error("write lost");
   a_locked_write: assert property ((REG_ADDR_IN == 8'h23 && !REG_WR_IN)
      ##1 (REG_ADDR_IN == 8'h23 && REG_WR_IN && !REG_UNLOCK_IN)
      ##1 (REG_ADDR_IN == 8'h23 && !REG_WR_IN)
      |=> $stable(REG_RDATA_OUT)) else $error("locked write taken");
   a_rail_cause: assert property ($changed(RAIL_EN_OUT) |->
      $past(STROBE_OUT) || $past(REG_WR_IN) || $past(REG_WR_IN, 2) ||
      $past(RESET_IN) || $past(RESET_IN, 2) ||
      $past(RAIL_DIRECT_EN_IN) != $past(RAIL_DIRECT_EN_IN, 2))
      else $error("rail moved without cause");
endmodule : rsa_seq_core_props

bind rsa_seq_core rsa_seq_core_props u_props (.*);

// [rsa_seq_core_tb_top.sv]
/* Self-checking bench for the slot sequencer.
   Assumes nothing beyond the design files. */
`timescale 1ns/1ps
module rsa_seq_core_tb_top;
   import rsa_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, unl = 1'b0, up = 1'b0;
   logic       dn = 1'b0, rd_go = 1'b0, rd_pend = 1'b0, stb_d = 1'b0;
   logic       ce = 1'b1;
   logic [7:0] gl = 8'h00, gh = 8'h00;
   logic       busy, stb;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdat, s;
   logic [3:0] num;
   logic [1:0] dir = 2'b00, rail;
   logic [7:0] exp_q[$];
   int         fails = 0, checks_done = 0, seed = 32'h1a3429bf, t;

   always #25 clk = ~clk;
   rsa_seq_core #(.GAP_SHORT(3), .GAP_LONG(7)) dut (
      .CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(ce),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
      .REG_UNLOCK_IN(unl), .REG_RDATA_OUT(rdat), .SEQ_UP_IN(up),
      .SEQ_DOWN_IN(dn), .SEQ_BUSY_OUT(busy), .STROBE_OUT(stb),
      .STROBE_NUM_OUT(num), .RAIL_DIRECT_EN_IN(dir), .RAIL_EN_OUT(rail));

   task automatic check(input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // ==========
   // Result watcher
   always @(posedge clk) begin
      if (rd_pend) begin
         check(rdat, exp_q.pop_front());
      end
      if (stb_d) begin
         check({6'h00, rail}, exp_q.pop_front());
      end
      rd_pend <= rd_go;
      stb_d   <= stb;
   end

   task automatic wr_reg(input logic [7:0] a, d, input logic u);
      @(posedge clk);
      addr <= a;
      wd   <= d;
      wr   <= 1'b1;
      unl  <= u;
      @(posedge clk);
      wr   <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, e);
      @(posedge clk);
      addr  <= a;
      rd_go <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd_go <= 1'b0;
   endtask : rd_reg

   // Rail state after strobe n of an up or down run
   function automatic logic [1:0] rail_exp(input logic [3:0] n, input logic u);
      logic [3:0] c;
      for (int i = 0; i < 2; i++) begin
         c = s[4*i +: 4];
         rail_exp[i] = dir[i] |
            (c >= 4'h3 && c <= 4'hA && (u ? n >= c : c < n));
      end
   endfunction : rail_exp

   task automatic run_seq(input logic u);
      logic [3:0] n;
      logic [8:0] g;
      logic [7:0] e;
      @(posedge clk);
      up <= u;
      dn <= ~u;
      @(posedge clk);
      up <= 1'b0;
      dn <= 1'b0;
      for (int k = 1; k <= 10; k++) begin
         n = 4'(u ? k : 11 - k);
         t = 0;
         do begin
            @(negedge clk);
            t++;
         end while (stb !== 1'b1 && t < 100);
         if (t >= 100) begin
            fails++;
            print_verdict();
         end
         check({4'h0, num}, {4'h0, n});
         if (k > 1) begin
            // Gap bit before strobe n, stretched tenfold going down when gh[7] is set
            g = {gh[0], gl};
            e = g[u ? n - 4'h2 : n - 4'h1] ? 8'h07 : 8'h03;
            if (!u && gh[7]) e = 8'(e * 8'h0A);
            check(8'(t), e);
         end
         check({7'h00, busy}, {7'h00, k != 10});
         exp_q.push_back({6'h00, rail_exp(n, u)});
      end
   endtask : run_seq

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h23, 8'h75);
      wr_reg(8'h23, 8'hA3, 1'b0);
      rd_reg(8'h23, 8'h75);
      rd_reg(8'h24, 8'h12);
      rd_reg(8'h30, 8'h00);
      wr_reg(8'h24, 8'hFF, 1'b1);
      rd_reg(8'h24, 8'h33);
      wr_reg(8'h20, 8'h01, 1'b1);
      gl = 8'h01;
      // Write with the clock enable low is not taken
      ce <= 1'b0;
      wr_reg(8'h20, 8'hFF, 1'b1);
      ce <= 1'b1;
      rd_reg(8'h20, 8'h01);
      s = 8'h75;
      run_seq(1'b1);
      run_seq(1'b0);
      for (int c = 0; c < 16; c++) begin
         s = {~4'(c), 4'(c)};
         wr_reg(8'h23, s, 1'b1);
         rd_reg(8'h23, s);
         dir <= 2'($random(seed));
         run_seq(1'b1);
         run_seq(1'b0);
      end
      // Gap nine long and tenfold stretch going down
      wr_reg(8'h21, 8'hFF, 1'b1);
      gh = 8'h81;
      rd_reg(8'h21, 8'h81);
      run_seq(1'b1);
      run_seq(1'b0);
      // Reset in mid-run restores registers and stops strobes
      @(posedge clk);
      up <= 1'b1;
      exp_q.push_back({6'h00, rail_exp(4'h1, 1'b1)});
      @(posedge clk);
      up <= 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({6'h00, busy, stb}, 8'h00);
      rd_reg(8'h21, 8'h00);
      rd_reg(8'h23, 8'h75);
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule : rsa_seq_core_tb_top
